// File: pllcc_map.vh
// Register offsets, field positions, field codes, reset values and divider code limits for the PLL configuration control
`ifndef PLLCC_MAP_VH
`define PLLCC_MAP_VH
// Register indices as printed (not all multiples of four; byte address is index times four)
`define PLLCC_IDX_PWR_POL_PUMP 10'h010
`define PLLCC_IDX_ANTIBACKLASH 10'h017
`define PLLCC_IDX_VCO_CAL 10'h018
`define PLLCC_IDX_CP_CURRENT 10'h019
`define PLLCC_IDX_VCO_DIVIDER 10'h1e0
`define PLLCC_IDX_DIST_SOURCE 10'h1e1
`define PLLCC_IDX_UPDATE 10'h232
`define PLLCC_IDX_STATUS 10'h233
// Field positions
`define PLLCC_PWR_LSB 0
`define PLLCC_PWR_MSB 1
`define PLLCC_CPM_LSB 4
`define PLLCC_CPM_MSB 6
`define PLLCC_POL_BIT 7
`define PLLCC_BYP_BIT 0
`define PLLCC_SRC_BIT 1
`define PLLCC_CAL_BIT 0
`define PLLCC_UPD_BIT 0
// Field codes
`define PLLCC_PWR_NORMAL 2'h0
`define PLLCC_PWR_DOWN 2'h1
`define PLLCC_CPM_HIZ 3'h0
`define PLLCC_CPM_UP 3'h1
`define PLLCC_CPM_DOWN 3'h2
`define PLLCC_CPM_NORMAL 3'h3
`define PLLCC_UPDATE_CODE 8'h01
// Reset values
`define PLLCC_RST_PWR_POL_PUMP 8'h01
`define PLLCC_RST_ANTIBACKLASH 8'h00
`define PLLCC_RST_VCO_CAL 8'h00
`define PLLCC_RST_CP_CURRENT 8'h07
`define PLLCC_RST_VCO_DIVIDER 8'h02
`define PLLCC_RST_DIST_SOURCE 8'h00
// VCO divider codes 0..4 give divide by 2..6
`define PLLCC_VDIV_MAX_CODE 3'h4
`define PLLCC_VDIV_BASE 3'h2
`endif

// File: pllcc_pfd.v
// Phase frequency detector with antibacklash stretch, charge pump mode and polarity steering
`timescale 1ns/1ps
`default_nettype none
`include "pllcc_map.vh"
module pllcc_pfd #(
   parameter ABW_W = 2
) (
   input wire clk_i, // System clock
   input wire sys_rst_i, // Synchronous reset, high
   input wire ref_edge_i, // Reference divider edge pulse
   input wire fb_edge_i, // Feedback divider edge pulse
   input wire run_i, // PLL powered and running
   input wire polarity_i, // 1 = negative polarity
   input wire [2:0] cp_mode_i, // Charge pump mode
   input wire [ABW_W-1:0] abw_i, // Antibacklash width code
   output reg pump_up_o, // Charge pump up command
   output reg pump_dn_o // Charge pump down command
);
   reg up_q;
   reg dn_q;
   reg [ABW_W+1:0] abw_cnt;
   reg [ABW_W+1:0] abw_len;
   reg raw_up;
   reg raw_dn;
   ////////////////////////////////////////////////////////////////////////////
   // Tri-state flip-flop detector; reset after both set, delayed by the pulse
   // width so that both outputs overlap and no dead zone remains
   always @(posedge clk_i) begin
      if (sys_rst_i || !run_i) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
         abw_cnt <= {(ABW_W+2){1'b0}};
      end else if (up_q && dn_q) begin
         if (abw_cnt >= abw_len) begin // R7
            up_q <= 1'b0;
            dn_q <= 1'b0;
            abw_cnt <= {(ABW_W+2){1'b0}};
         end else begin
            abw_cnt <= abw_cnt + {{(ABW_W+1){1'b0}}, 1'b1};
         end
      end else begin
         if (ref_edge_i) begin
            up_q <= 1'b1; // R10
         end
         if (fb_edge_i) begin
            dn_q <= 1'b1; // R10
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Width code 0..3 maps to 1..4 cycles of overlap
   always @* begin
      abw_len = {2'b00, abw_i}; // R7
   end
   ////////////////////////////////////////////////////////////////////////////
   // Mode and polarity select what reaches the pump
   always @* begin
      raw_up = polarity_i ? dn_q : up_q; // R4
      raw_dn = polarity_i ? up_q : dn_q; // R4
   end
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         pump_up_o <= 1'b0;
         pump_dn_o <= 1'b0;
      end else begin
         case (cp_mode_i) // R8
            `PLLCC_CPM_HIZ: begin
               pump_up_o <= 1'b0;
               pump_dn_o <= 1'b0;
            end
            `PLLCC_CPM_UP: begin
               pump_up_o <= run_i;
               pump_dn_o <= 1'b0;
            end
            `PLLCC_CPM_DOWN: begin
               pump_up_o <= 1'b0;
               pump_dn_o <= run_i;
            end
            `PLLCC_CPM_NORMAL: begin
               pump_up_o <= raw_up;
               pump_dn_o <= raw_dn;
            end
            default: begin
               pump_up_o <= 1'b0; // Unused codes hold the loop like high impedance
               pump_dn_o <= 1'b0;
            end
         endcase
      end
   end
endmodule // pllcc_pfd
`default_nettype wire

// File: pllcc_top.v
// PLL configuration control: APB register file, shadow/active staging, source path, pump control
// Contract
// [R1] Power field 0x010[1:0]: 01 powers PLL down, 00 runs it.
// [R2] 0x1E1[0]=1 bypasses VCO divider, distribution fed from chosen source.
// [R3] 0x1E1[1]=0 selects external clock input as distribution source.
// [R4] 0x010[7] sets detector polarity: 0 positive, 1 negative.
// [R5] New settings act only after host writes 0x01 to 0x232.
// [R6] Host enables PLL when external oscillator below limit bypasses divider.
// [R7] Antibacklash pulse width chosen by 0x017[1:0].
// [R8] Pump mode 0x010[6:4]: high impedance, normal, forced up, forced down.
// [R9] Pump current set in eight steps, 600 uA to 4.8 mA.
// [R10] Detector compares reference and feedback edges, commands pump up or down.
// [R11] Host calibrates VCO at first setup and after frequency changes.
// [R12] During calibration reference toggles and VCO divider clock runs.
// [R13] 0x1E1[1]=1 selects internal VCO as distribution source.
// [R14] Calibrate: clear 0x018[0], update, set it, update again.
// [R15] 0x1E0[2:0] sets VCO divide 2 to 6, default divide by 4.
// [R16] Writes staged in shadow, copied in one cycle on update; bit self-clears.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pllcc_map.vh"
module pllcc_top #(
   parameter ABW_W = 2,
   parameter CPI_W = 3
) (
   input wire clk_i, // System clock, 50 MHz
   input wire sys_rst_i, // Synchronous reset, high
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire pwrite, // APB direction
   input wire [11:0] paddr, // APB byte address
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output reg pready, // APB ready
   output reg pslverr, // APB error on unmapped address
   input wire ref_clk_i, // Reference divider output, asynchronous
   input wire fb_clk_i, // Feedback divider output, asynchronous
   input wire ext_clk_i, // External clock input, asynchronous
   input wire vco_clk_i, // Internal VCO tap, asynchronous
   output reg pll_pwr_down_o, // PLL powered down
   output reg pump_up_o, // Charge pump up
   output reg pump_dn_o, // Charge pump down
   output reg [CPI_W-1:0] cp_current_o, // Pump current step
   output reg [ABW_W-1:0] abw_o, // Antibacklash width code
   output reg vco_sel_o, // 1 = internal VCO source
   output reg div_bypass_o, // 1 = VCO divider bypassed
   output reg [2:0] vco_div_o, // Divide ratio, 2..6
   output reg dist_clk_o, // Clock to distribution section
   output reg vco_cal_start_o, // One-cycle pulse when calibration begins
   output reg cal_ready_o // Reference and source both toggling
);
   // Shadow registers, written by software
   reg [7:0] sh_ppp;
   reg [7:0] sh_abw;
   reg [7:0] sh_cal;
   reg [7:0] sh_cpi;
   reg [7:0] sh_vdiv;
   reg [7:0] sh_src;
   // Active registers, loaded only on update
   reg [7:0] ac_ppp;
   reg [7:0] ac_abw;
   reg [7:0] ac_cal;
   reg [7:0] ac_cpi;
   reg [7:0] ac_vdiv;
   reg [7:0] ac_src;
   reg update;
   reg [7:0] next_rdata;
   reg addr_ok;
   wire [9:0] idx;
   wire acc;
   wire wr;
   // Three-stage synchronisers for the asynchronous pins
   reg [3:0] sync1;
   reg [3:0] sync2;
   reg [3:0] sync3;
   wire ref_edge;
   wire fb_edge;
   wire ext_edge;
   wire vco_edge;
   wire src_edge;
   reg [2:0] div_cnt;
   reg [2:0] div_ratio;
   reg [3:0] act_cnt;
   reg [3:0] ref_seen;
   reg [3:0] src_seen;
   wire pfd_up;
   wire pfd_dn;
   // Pump current reset follows the active register reset so the output never steps after reset
   localparam [7:0] RST_CPI = `PLLCC_RST_CP_CURRENT;
   ////////////////////////////////////////////////////////////////////////////
   // APB decode; each index occupies one word
   assign idx = paddr[11:2];
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite && addr_ok;
   always @* begin
      addr_ok = 1'b1;
      next_rdata = 8'h00;
      case (idx)
         `PLLCC_IDX_PWR_POL_PUMP: next_rdata = sh_ppp;
         `PLLCC_IDX_ANTIBACKLASH: next_rdata = sh_abw;
         `PLLCC_IDX_VCO_CAL: next_rdata = sh_cal;
         `PLLCC_IDX_CP_CURRENT: next_rdata = sh_cpi;
         `PLLCC_IDX_VCO_DIVIDER: next_rdata = sh_vdiv;
         `PLLCC_IDX_DIST_SOURCE: next_rdata = sh_src;
         `PLLCC_IDX_UPDATE: next_rdata = {7'h00, update};
         `PLLCC_IDX_STATUS: next_rdata = {5'h00, cal_ready_o, pll_pwr_down_o, vco_sel_o};
         default: addr_ok = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // Slave answers in the second access cycle: ready rises one cycle after penable
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !addr_ok;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= {24'h000000, next_rdata};
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Shadow writes; update loads active copies in one cycle and self-clears
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         sh_ppp <= `PLLCC_RST_PWR_POL_PUMP;
         sh_abw <= `PLLCC_RST_ANTIBACKLASH;
         sh_cal <= `PLLCC_RST_VCO_CAL;
         sh_cpi <= `PLLCC_RST_CP_CURRENT;
         sh_vdiv <= `PLLCC_RST_VCO_DIVIDER;
         sh_src <= `PLLCC_RST_DIST_SOURCE;
         update <= 1'b0;
      end else begin
         update <= 1'b0; // R16
         if (wr) begin
            case (idx)
               `PLLCC_IDX_PWR_POL_PUMP: sh_ppp <= pwdata[7:0];
               `PLLCC_IDX_ANTIBACKLASH: sh_abw <= pwdata[7:0];
               `PLLCC_IDX_VCO_CAL: sh_cal <= pwdata[7:0];
               `PLLCC_IDX_CP_CURRENT: sh_cpi <= pwdata[7:0];
               `PLLCC_IDX_VCO_DIVIDER: sh_vdiv <= pwdata[7:0];
               `PLLCC_IDX_DIST_SOURCE: sh_src <= pwdata[7:0];
               `PLLCC_IDX_UPDATE: update <= (pwdata[7:0] == `PLLCC_UPDATE_CODE); // R5
               default: update <= 1'b0;
            endcase
         end
      end
   end
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         ac_ppp <= `PLLCC_RST_PWR_POL_PUMP;
         ac_abw <= `PLLCC_RST_ANTIBACKLASH;
         ac_cal <= `PLLCC_RST_VCO_CAL;
         ac_cpi <= `PLLCC_RST_CP_CURRENT;
         ac_vdiv <= `PLLCC_RST_VCO_DIVIDER;
         ac_src <= `PLLCC_RST_DIST_SOURCE;
      end else if (update) begin
         ac_ppp <= sh_ppp; // R5 R16
         ac_abw <= sh_abw;
         ac_cal <= sh_cal;
         ac_cpi <= sh_cpi;
         ac_vdiv <= sh_vdiv;
         ac_src <= sh_src;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Active settings to outputs; unused divider codes clamp to the largest ratio
   always @* begin
      if (ac_vdiv[2:0] > `PLLCC_VDIV_MAX_CODE) begin
         div_ratio = `PLLCC_VDIV_MAX_CODE + `PLLCC_VDIV_BASE; // R15
      end else begin
         div_ratio = ac_vdiv[2:0] + `PLLCC_VDIV_BASE; // R15
      end
   end
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         pll_pwr_down_o <= 1'b1;
         cp_current_o <= RST_CPI[CPI_W-1:0];
         abw_o <= {ABW_W{1'b0}};
         vco_sel_o <= 1'b0;
         div_bypass_o <= 1'b0;
         vco_div_o <= 3'h4;
         vco_cal_start_o <= 1'b0;
      end else begin
         // Only 00 runs the PLL; other codes are treated as off for safety
         pll_pwr_down_o <= (ac_ppp[`PLLCC_PWR_MSB:`PLLCC_PWR_LSB] != `PLLCC_PWR_NORMAL); // R1
         cp_current_o <= ac_cpi[CPI_W-1:0]; // R9
         abw_o <= ac_abw[ABW_W-1:0]; // R7
         vco_sel_o <= ac_src[`PLLCC_SRC_BIT]; // R3 R13
         div_bypass_o <= ac_src[`PLLCC_BYP_BIT]; // R2
         vco_div_o <= div_ratio; // R15
         // Calibration launches when the bit goes from 0 to 1 at update
         vco_cal_start_o <= update && sh_cal[`PLLCC_CAL_BIT] && !ac_cal[`PLLCC_CAL_BIT]; // R14
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Synchronise pins; edges read only the second and third stages
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
      end else begin
         sync1 <= {vco_clk_i, ext_clk_i, fb_clk_i, ref_clk_i};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   assign ref_edge = sync2[0] && !sync3[0];
   assign fb_edge = sync2[1] && !sync3[1];
   assign ext_edge = sync2[2] && !sync3[2];
   assign vco_edge = sync2[3] && !sync3[3];
   assign src_edge = vco_sel_o ? vco_edge : ext_edge; // R3 R13
   ////////////////////////////////////////////////////////////////////////////
   // Divider toggles once per ratio source edges; bypass passes the source level
   // Limitation: sampled at 50 MHz, so only slow test clocks are reproduced faithfully
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         div_cnt <= 3'h0;
         dist_clk_o <= 1'b0;
      end else if (div_bypass_o) begin
         div_cnt <= 3'h0;
         dist_clk_o <= vco_sel_o ? sync3[3] : sync3[2]; // R2
      end else if (src_edge) begin
         if (div_cnt >= div_ratio - 3'h1) begin
            div_cnt <= 3'h0;
            dist_clk_o <= !dist_clk_o; // R15
         end else begin
            div_cnt <= div_cnt + 3'h1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Activity monitor: both inputs must show an edge within a window
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         act_cnt <= 4'h0;
         ref_seen <= 4'h0;
         src_seen <= 4'h0;
         cal_ready_o <= 1'b0;
      end else begin
         act_cnt <= act_cnt + 4'h1;
         if (act_cnt == 4'hf) begin
            // An edge in the closing cycle counts too, else it would be lost between windows
            cal_ready_o <= (ref_seen != 4'h0 || ref_edge) && (src_seen != 4'h0 || src_edge); // R12
            ref_seen <= 4'h0;
            src_seen <= 4'h0;
         end else begin
            ref_seen <= ref_seen | {3'h0, ref_edge};
            src_seen <= src_seen | {3'h0, src_edge};
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Detector and pump
   pllcc_pfd #(
      .ABW_W(ABW_W)
   ) u_pfd (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ref_edge_i(ref_edge),
      .fb_edge_i(fb_edge),
      .run_i(!pll_pwr_down_o),
      .polarity_i(ac_ppp[`PLLCC_POL_BIT]),
      .cp_mode_i(ac_ppp[`PLLCC_CPM_MSB:`PLLCC_CPM_LSB]),
      .abw_i(abw_o),
      .pump_up_o(pfd_up),
      .pump_dn_o(pfd_dn)
   );
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         pump_up_o <= 1'b0;
         pump_dn_o <= 1'b0;
      end else begin
         // A powered-down loop must not pump, even if the detector is mid-pulse
         pump_up_o <= pfd_up && !pll_pwr_down_o; // R1 R10
         pump_dn_o <= pfd_dn && !pll_pwr_down_o; // R1 R10
      end
   end
endmodule // pllcc_top
`default_nettype wire

// File: pllcc_analog_model.sv
// Behavioural analog side: reference, feedback, external and VCO clocks
`timescale 1ns/1ps
`default_nettype none
module pllcc_analog_model #(
   parameter integer REF_HALF = 130, // Period must fit the 16-cycle activity window
   parameter integer FB_LAG = 60
) (
   input wire logic ref_run_i, // Reference present
   output var logic ref_clk_o, // Reference divider out
   output var logic fb_clk_o, // Feedback divider out
   output var logic ext_clk_o, // External clock
   output var logic vco_clk_o // VCO tap
);
   // Reference stops when absent; feedback trails it so the detector sees a phase error
   initial begin
      ref_clk_o = 1'b0;
      fb_clk_o = 1'b0;
      ext_clk_o = 1'b0;
      vco_clk_o = 1'b0;
      fork
         forever #(REF_HALF) ref_clk_o = ref_clk_o ^ ref_run_i;
         forever @(ref_clk_o) fb_clk_o <= #(FB_LAG) ref_clk_o;
         forever #70 ext_clk_o = ~ext_clk_o;
         forever #50 vco_clk_o = ~vco_clk_o;
      join
   end
endmodule // pllcc_analog_model
`default_nettype wire

// File: pllcc_top_sva.sv
// Checker for bus answers, staging and pump behaviour of the PLL configuration control
`timescale 1ns/1ps
`default_nettype none
module pllcc_top_sva #(
   parameter CPI_W = 3
) (
   input wire logic clk_i, // Clock
   input wire logic sys_rst_i, // Reset
   input wire logic psel, // APB
   input wire logic penable, // APB
   input wire logic pwrite, // APB
   input wire logic [11:0] paddr, // APB
   input wire logic [31:0] pwdata, // APB
   input wire logic [31:0] prdata, // APB
   input wire logic pready, // APB
   input wire logic pslverr, // APB
   input wire logic pll_pwr_down_o, // Power
   input wire logic pump_up_o, // Pump
   input wire logic pump_dn_o, // Pump
   input wire logic [CPI_W-1:0] cp_current_o, // Current
   input wire logic vco_sel_o, // Source
   input wire logic div_bypass_o, // Bypass
   input wire logic [2:0] vco_div_o, // Ratio
   input wire logic vco_cal_start_o // Cal pulse
);
   logic mapped;
   logic upd_w;
   logic [6:0] upd_sr;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////
   // Decoded index and accepted update strobe, as seen on the bus
   assign mapped = paddr[11:2] inside {10'h010, 10'h017, 10'h018, 10'h019, 10'h1e0, 10'h1e1,
      10'h232, 10'h233};
   assign upd_w = psel && penable && pready && pwrite && paddr[11:2] == 10'h232
      && pwdata[7:0] == 8'h01;
   // Recent update history; a change of power, source, bypass, ratio or current output must trace back to one
   always @(posedge clk_i) begin
      if (sys_rst_i) upd_sr <= 7'h00;
      else upd_sr <= {upd_sr[5:0], upd_w};
   end
   property p_ready;
      $rose(penable) && psel |-> !pready ##1 pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready timing wrong");
   property p_err_map;
      pready |-> pslverr == !mapped;
   endproperty
   a_err_map: assert property (p_err_map) else $error("pslverr wrong");
   property p_rdata;
      pready && !pwrite |-> prdata[31:8] == 24'h0 && (mapped || prdata[7:0] == 8'h00);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data wrong");
   property p_staged;
      !$stable({pll_pwr_down_o, vco_sel_o, div_bypass_o, vco_div_o, cp_current_o}) |-> |upd_sr;
   endproperty
   a_staged: assert property (p_staged) else $error("setting changed without update");
   property p_cal;
      vco_cal_start_o |-> |upd_sr ##1 !vco_cal_start_o;
   endproperty
   a_cal: assert property (p_cal) else $error("calibration pulse wrong");
   property p_pwr_pump;
      pll_pwr_down_o [*3] |-> !pump_up_o && !pump_dn_o;
   endproperty
   a_pwr_pump: assert property (p_pwr_pump) else $error("pump active while down");
   property p_div_range;
      vco_div_o >= 3'h2 && vco_div_o <= 3'h6;
   endproperty
   a_div_range: assert property (p_div_range) else $error("divide ratio out of range");
   property p_rst_val;
      $fell(sys_rst_i) |-> pll_pwr_down_o && vco_div_o == 3'h4 && !vco_sel_o && !div_bypass_o;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("reset state wrong");
   c_upd: cover property (upd_w);
   c_err: cover property (pready && pslverr);
   c_cal: cover property (vco_cal_start_o);
   c_up: cover property (pump_up_o && !pll_pwr_down_o);
endmodule // pllcc_top_sva
bind pllcc_top pllcc_top_sva #(.CPI_W(CPI_W)) i_pllcc_top_sva (.clk_i(clk_i),
   .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pll_pwr_down_o(pll_pwr_down_o), .pump_up_o(pump_up_o), .pump_dn_o(pump_dn_o),
   .cp_current_o(cp_current_o), .vco_sel_o(vco_sel_o), .div_bypass_o(div_bypass_o),
   .vco_div_o(vco_div_o), .vco_cal_start_o(vco_cal_start_o));
`default_nettype wire

// File: pllcc_top_tb.sv
// Self-checking bench for the PLL configuration control block
`timescale 1ns/1ps
`default_nettype none
module pllcc_top_tb;
   logic clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, ref_run, er_s, dprev;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic ref_c, fb_c, ext_c, vco_c, pwr_dn, up, dn, vsel, byp, dclk, cal_st, cal_rdy;
   logic [2:0] cpi, vdiv;
   logic [1:0] abw;
   logic [7:0] rd_s;
   integer errors, total_checks, cal_n, i, n, m;
   pllcc_analog_model i_pllcc_analog_model (.ref_run_i(ref_run), .ref_clk_o(ref_c),
      .fb_clk_o(fb_c), .ext_clk_o(ext_c), .vco_clk_o(vco_c));
   pllcc_top i_pllcc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ref_clk_i(ref_c), .fb_clk_i(fb_c), .ext_clk_i(ext_c),
      .vco_clk_i(vco_c), .pll_pwr_down_o(pwr_dn), .pump_up_o(up), .pump_dn_o(dn),
      .cp_current_o(cpi), .abw_o(abw), .vco_sel_o(vsel), .div_bypass_o(byp), .vco_div_o(vdiv),
      .dist_clk_o(dclk), .vco_cal_start_o(cal_st), .cal_ready_o(cal_rdy));
   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("Checks %0d, errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One APB transfer; request held until pready is sampled high, then released
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      integer k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk_i);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k = k + 1;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) begin
         errors = errors + 1;
         stop_test();
      end
      rd_s = prdata[7:0];
      er_s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [9:0] idx, input logic [7:0] exp, input logic err);
      apb(1'b0, idx, 8'h00);
      check({23'h0, er_s, rd_s}, {23'h0, err, exp});
   endtask
   // Update write, then count calibration pulses while the staged values land
   task automatic upd(input logic [7:0] code);
      apb(1'b1, 10'h232, code);
      cal_n = 0;
      repeat (6) begin
         @(posedge clk_i);
         cal_n = cal_n + (cal_st === 1'b1);
      end
   endtask
   task automatic chk_out(input logic [10:0] e);
      check({21'h0, pwr_dn, vsel, byp, abw, cpi, vdiv}, {21'h0, e});
   endtask
   ////////////////////////////////////////
   initial begin
      errors = 0;
      total_checks = 0;
      sys_rst_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ref_run = 1'b1;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      chk_out(11'h43c);
      rdc(10'h010, 8'h01, 1'b0);
      rdc(10'h017, 8'h00, 1'b0);
      rdc(10'h019, 8'h07, 1'b0);
      rdc(10'h1e0, 8'h02, 1'b0);
      rdc(10'h1e1, 8'h00, 1'b0);
      rdc(10'h011, 8'h00, 1'b1);
      // Stage every setting except calibration; nothing moves until the 0x01 strobe
      apb(1'b1, 10'h010, 8'h30);
      apb(1'b1, 10'h017, 8'h02);
      apb(1'b1, 10'h019, 8'h04);
      apb(1'b1, 10'h1e0, 8'h00);
      apb(1'b1, 10'h1e1, 8'h03);
      rdc(10'h1e1, 8'h03, 1'b0);
      chk_out(11'h43c);
      upd(8'h02);
      chk_out(11'h43c);
      upd(8'h01);
      chk_out(11'h3a2);
      rdc(10'h232, 8'h00, 1'b0);
      // Forced pump modes and high impedance
      for (i = 0; i < 3; i = i + 1) begin
         apb(1'b1, 10'h010, {1'b0, i[2:0], 4'h0});
         upd(8'h01);
         check({30'h0, up, dn}, {30'h0, i == 1, i == 2});
      end
      // Normal mode with reference leading: direction follows polarity
      for (i = 0; i < 2; i = i + 1) begin
         apb(1'b1, 10'h010, {i[0], 7'h30});
         upd(8'h01);
         n = 0;
         m = 0;
         repeat (200) begin
            @(posedge clk_i);
            n = n + (up === 1'b1);
            m = m + (dn === 1'b1);
         end
         check({31'h0, n > m}, {31'h0, i == 0});
      end
      apb(1'b1, 10'h010, 8'h31);
      upd(8'h01);
      check({29'h0, pwr_dn, up, dn}, 32'h4);
      // Calibration with the VCO selected through a clamped divider
      apb(1'b1, 10'h010, 8'h30);
      apb(1'b1, 10'h018, 8'h01);
      apb(1'b1, 10'h1e1, 8'h02);
      apb(1'b1, 10'h1e0, 8'h07);
      upd(8'h01);
      check(cal_n, 1);
      chk_out(11'h2a6);
      repeat (40) @(posedge clk_i);
      check({31'h0, cal_rdy}, 32'h1);
      rdc(10'h233, 8'h05, 1'b0);
      apb(1'b1, 10'h018, 8'h00);
      upd(8'h01);
      check(cal_n, 0);
      apb(1'b1, 10'h018, 8'h01);
      upd(8'h01);
      check(cal_n, 1);
      ref_run <= 1'b0;
      repeat (60) @(posedge clk_i);
      check({31'h0, cal_rdy}, 32'h0);
      ref_run <= 1'b1;
      // External clock straight to distribution, PLL left on
      apb(1'b1, 10'h1e1, 8'h01);
      upd(8'h01);
      check({30'h0, vsel, byp}, 32'h1);
      n = 0;
      dprev = dclk;
      repeat (64) begin
         @(posedge clk_i);
         n = n + (dclk !== dprev);
         dprev = dclk;
      end
      check({31'h0, n > 8}, 32'h1);
      // Second reset in mid-run restores defaults
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      chk_out(11'h43c);
      rdc(10'h010, 8'h01, 1'b0);
      stop_test();
   end
endmodule // pllcc_top_tb
`default_nettype wire
